// File: hw/sspi_map.svh
// constants for the sensor serial slave port and sync logic
`ifndef SSPI_MAP_SVH
`define SSPI_MAP_SVH
`define SSPI_CLK_MHZ 25
`define SSPI_FRAME_BITS 16
`define SSPI_ADDR_BITS 7
`define SSPI_WADDR_BITS 6
`define SSPI_REG_COUNT 64
`define SSPI_LOWPWR_MIN 8'h0A
`define SSPI_SYNC_TO_READY_US 600
`define SSPI_SYNC_TO_READY_CYC (`SSPI_SYNC_TO_READY_US * `SSPI_CLK_MHZ)
`define SSPI_READY_PULSE_CYC 25
`define SSPI_BURST_CMD 16'h3E00
`define SSPI_PERIOD_ADDR 6'h36
`define SSPI_PERIOD_RESET 8'h01
`define SSPI_GPIO4_MODE_ADDR 6'h32
`define SSPI_GPIO4_MODE_BIT 2
`define SSPI_GPIO4_DIR_BIT 3
`define SSPI_GPIO4_OUT_BIT 7
`endif

// File: hw/sspi_pkg.sv
// types for the sensor serial slave port
package sspi_pkg;
  typedef enum logic [1:0] {
    SSPI_NORMAL,
    SSPI_LOW_POWER,
    SSPI_BURST
  } sspi_mode_t;
  typedef enum logic [1:0] {
    SSPI_IDLE,
    SSPI_WAIT,
    SSPI_PULSE
  } sspi_sync_t;
endpackage

// File: hw/sspi_sync2.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module sspi_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage1;
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1 <= '0;
      q <= '0;
    end else begin
      stage1 <= d;
      q <= stage1;
    end
  end
endmodule

// File: hw/sspi_slave.sv
// serial slave port, register store and external sync pacing
`timescale 1ns/1ns
`include "sspi_map.svh"
//
// Operation
// - output bit changes on serial clock falling edge
// - input bit captured on serial clock rising edge while selected
// - data ready asserts 600 us after a sync pulse seen while idle; pulses during the wait are ignored
// - gpio4 acts as general i/o or as sync clock input
// - period setting 0x09 or less is normal, 0x0A or more low power
// - read: address frame, then register contents in next frame
// - msb set: low byte written to six-bit address at frame end
module sspi_slave (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic DIN,
  output logic DOUT,
  input wire logic GPIO4_IN,
  output logic GPIO4_OUT,
  output logic GPIO4_OE,
  output logic GPIO1_DATA_READY,
  input wire logic SAMPLE_LOAD,
  output logic [1:0] MODE,
  output logic [7:0] SAMPLE_PERIOD_SETTING,
  output logic WRITE_STROBE,
  output logic [5:0] WRITE_ADDR,
  output logic [7:0] WRITE_DATA
);
  logic [3:0] pins;
  logic cs_n_s;
  logic sclk_s;
  logic din_s;
  logic gpio4_s;
  logic sclk_d;
  logic cs_n_d;
  logic gpio4_d;
  logic [7:0] regs [0:`SSPI_REG_COUNT-1];
  logic [15:0] shift_in;
  logic [15:0] shift_out;
  logic [4:0] bit_count;
  logic [6:0] read_addr;
  sspi_pkg::sspi_sync_t sync_state;
  logic [15:0] sync_count;
  logic sync_mode;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic frame_done;
  logic [15:0] next_frame;
  logic [7:0] period;
  logic [15:0] read_word;

  function automatic logic [15:0] reg_word(input logic [6:0] addr);
    logic [5:0] lo;
    lo = {addr[5:1], 1'b0};
    reg_word = {regs[lo | 6'h01], regs[lo]};
  endfunction

  sspi_sync2 #(
    .WIDTH(4)
  ) u_sync (
    .clk(REF_CLK),
    .rst(RESET),
    .d({~CS_N, ~SCLK, DIN, GPIO4_IN}),
    .q(pins)
  );
  // idle-high pins pass inverted so the cleared synchroniser reads as idle
  assign cs_n_s = ~pins[3];
  assign sclk_s = ~pins[2];
  assign din_s = pins[1];
  assign gpio4_s = pins[0];

  // ----------------------------------------
  // edge detection
  // ----------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      sclk_d <= 1'b1;
      cs_n_d <= 1'b1;
      gpio4_d <= 1'b0;
    end else begin
      sclk_d <= sclk_s;
      cs_n_d <= cs_n_s;
      gpio4_d <= gpio4_s;
    end
  end
  assign sclk_rise = !cs_n_s && sclk_s && !sclk_d;
  assign sclk_fall = !cs_n_s && !sclk_s && sclk_d;
  assign cs_fall = !cs_n_s && cs_n_d;
  assign cs_rise = cs_n_s && !cs_n_d;
  assign next_frame = {shift_in[14:0], din_s};
  assign frame_done = sclk_rise && (bit_count == 5'(`SSPI_FRAME_BITS - 1));
  assign period = regs[`SSPI_PERIOD_ADDR];
  always_comb begin
    read_word = reg_word(read_addr);
  end

  // ----------------------------------------
  // mode selection
  // ----------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      MODE <= 2'(sspi_pkg::SSPI_NORMAL);
    end else if (read_addr == 7'(`SSPI_BURST_CMD >> 8) && bit_count != 5'h0) begin
      MODE <= 2'(sspi_pkg::SSPI_BURST);
    end else if (period >= `SSPI_LOWPWR_MIN) begin
      MODE <= 2'(sspi_pkg::SSPI_LOW_POWER);
    end else begin
      MODE <= 2'(sspi_pkg::SSPI_NORMAL);
    end
  end
  assign SAMPLE_PERIOD_SETTING = period;

  // ----------------------------------------
  // serial receive
  // ----------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      shift_in <= 16'h0000;
      bit_count <= 5'h00;
      read_addr <= 7'h00;
    end else if (cs_fall) begin
      bit_count <= 5'h00;
    end else if (sclk_rise) begin
      shift_in <= next_frame;
      if (frame_done) begin
        bit_count <= 5'h00;
        if (!next_frame[15]) begin
          read_addr <= next_frame[14:8];
        end
      end else begin
        bit_count <= bit_count + 5'h01;
      end
    end
  end

  // ----------------------------------------
  // register store and writes
  // ----------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      for (int i = 0; i < `SSPI_REG_COUNT; i++) begin
        regs[i] <= 8'h00;
      end
      regs[`SSPI_PERIOD_ADDR] <= `SSPI_PERIOD_RESET;
      WRITE_STROBE <= 1'b0;
      WRITE_ADDR <= 6'h00;
      WRITE_DATA <= 8'h00;
    end else begin
      WRITE_STROBE <= 1'b0;
      if (frame_done && next_frame[15]) begin
        regs[next_frame[13:8]] <= next_frame[7:0];
        WRITE_STROBE <= 1'b1;
        WRITE_ADDR <= next_frame[13:8];
        WRITE_DATA <= next_frame[7:0];
      end
    end
  end

  // ----------------------------------------
  // serial transmit
  // ----------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      shift_out <= 16'h0000;
      DOUT <= 1'b0;
    end else if (cs_fall) begin
      shift_out <= {read_word[14:0], 1'b0};
      DOUT <= read_word[15];
    end else if (frame_done) begin
      shift_out <= {read_word[14:0], 1'b0};
      DOUT <= DOUT;
    end else if (sclk_fall && bit_count != 5'h0) begin
      DOUT <= shift_out[15];
      shift_out <= {shift_out[14:0], 1'b0};
    end else if (sclk_fall) begin
      DOUT <= read_word[15];
      shift_out <= {read_word[14:0], 1'b0};
    end else if (cs_rise) begin
      DOUT <= 1'b0;
    end
  end

  // ----------------------------------------
  // gpio4 and sync pacing
  // ----------------------------------------
  assign sync_mode = regs[`SSPI_GPIO4_MODE_ADDR][`SSPI_GPIO4_MODE_BIT];
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      GPIO4_OE <= 1'b0;
      GPIO4_OUT <= 1'b0;
    end else begin
      GPIO4_OE <= !sync_mode && regs[`SSPI_GPIO4_MODE_ADDR][`SSPI_GPIO4_DIR_BIT];
      GPIO4_OUT <= regs[`SSPI_GPIO4_MODE_ADDR][`SSPI_GPIO4_OUT_BIT];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      sync_state <= sspi_pkg::SSPI_IDLE;
      sync_count <= 16'h0000;
      GPIO1_DATA_READY <= 1'b0;
    end else begin
      case (sync_state)
        sspi_pkg::SSPI_IDLE: begin
          GPIO1_DATA_READY <= 1'b0;
          if (sync_mode && gpio4_s && !gpio4_d) begin
            sync_state <= sspi_pkg::SSPI_WAIT;
            sync_count <= 16'h0000;
          end else if (!sync_mode && SAMPLE_LOAD) begin
            sync_state <= sspi_pkg::SSPI_PULSE;
            sync_count <= 16'h0000;
          end
        end
        sspi_pkg::SSPI_WAIT: begin
          if (sync_count == 16'(`SSPI_SYNC_TO_READY_CYC - 1)) begin
            sync_state <= sspi_pkg::SSPI_PULSE;
            sync_count <= 16'h0000;
          end else begin
            sync_count <= sync_count + 16'h0001;
          end
        end
        sspi_pkg::SSPI_PULSE: begin
          GPIO1_DATA_READY <= 1'b1;
          if (sync_count == 16'(`SSPI_READY_PULSE_CYC - 1)) begin
            sync_state <= sspi_pkg::SSPI_IDLE;
          end else begin
            sync_count <= sync_count + 16'h0001;
          end
        end
        default: begin
          sync_state <= sspi_pkg::SSPI_IDLE;
        end
      endcase
    end
  end
endmodule

// File: verification/sspi_host_model.sv
// serial master model for the slave port
`timescale 1ns/1ns
module sspi_host_model (
  input wire logic clk,
  output logic cs_n,
  output logic sclk,
  output logic din,
  input wire logic dout
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    din = 1'b0;
  end
  // n bits msb first; dout taken at each rise
  task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    repeat (3750) @(posedge clk);
    #1 cs_n = 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      // four ref clocks per link clock phase, 320 ns period
      repeat (4) @(posedge clk);
      #1 sclk = 1'b0;
      din = tx[i];
      repeat (4) @(posedge clk);
      #1 sclk = 1'b1;
      rx[i] = dout;
    end
    repeat (8) @(posedge clk);
    #1 cs_n = 1'b1;
    din = ~din;
  endtask
  // clock and data wiggle while deselected; slave must ignore them
  task automatic idle_clocks(input int n);
    repeat (n) begin
      repeat (4) @(posedge clk);
      #1 sclk = 1'b0;
      din = ~din;
      repeat (4) @(posedge clk);
      #1 sclk = 1'b1;
    end
  endtask
endmodule

// File: verification/sspi_slave_checker.sv
// pin level assertions for the slave port
`timescale 1ns/1ns
`include "sspi_map.svh"
module sspi_slave_checker (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic DOUT,
  input wire logic GPIO4_OE,
  input wire logic GPIO1_DATA_READY,
  input wire logic [1:0] MODE,
  input wire logic [7:0] SAMPLE_PERIOD_SETTING,
  input wire logic WRITE_STROBE,
  input wire logic [5:0] WRITE_ADDR,
  input wire logic [7:0] WRITE_DATA
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  dout_hold_a: assert property ($rose(SCLK) && !CS_N |=> $stable(DOUT) [*4])
    else $error("dout moved after rise");
  lp_mode_a: assert property ((SAMPLE_PERIOD_SETTING > 8'h09) [*3] |-> MODE != sspi_pkg::SSPI_NORMAL)
    else $error("low power not shown");
  norm_mode_a: assert property ((SAMPLE_PERIOD_SETTING < 8'h0A) [*3] |-> MODE != sspi_pkg::SSPI_LOW_POWER)
    else $error("normal not shown");
  ready_width_a: assert property ($fell(GPIO1_DATA_READY) |->
    $past(GPIO1_DATA_READY, 25) && !$past(GPIO1_DATA_READY, 26)) else $error("ready width");
  strobe_one_a: assert property (WRITE_STROBE |=> !WRITE_STROBE) else $error("strobe long");
  strobe_sel_a: assert property (WRITE_STROBE |-> !$past(CS_N, 6)) else $error("strobe unselected");
  period_wr_a: assert property (WRITE_STROBE && WRITE_ADDR == `SSPI_PERIOD_ADDR |->
    ##2 SAMPLE_PERIOD_SETTING == WRITE_DATA) else $error("period not written");
  gpio_dir_a: assert property (WRITE_STROBE && WRITE_ADDR == `SSPI_GPIO4_MODE_ADDR |->
    ##2 GPIO4_OE == (WRITE_DATA[3] && !WRITE_DATA[2])) else $error("gpio4 enable");
  cover property ($rose(GPIO1_DATA_READY));
  cover property (WRITE_STROBE);
  cover property (MODE == sspi_pkg::SSPI_LOW_POWER);
  cover property (MODE == sspi_pkg::SSPI_BURST);
endmodule
bind sspi_slave sspi_slave_checker u_chk (.*);

// File: verification/sensor_spi_slave_timing_sync_tb_top.sv
// self-checking bench for the slave port
`timescale 1ns/1ns
module sensor_spi_slave_timing_sync_tb_top;
  logic REF_CLK = 1'b0;
  logic RESET = 1'b1;
  logic GPIO4_IN = 1'b0;
  logic SAMPLE_LOAD = 1'b0;
  logic CS_N, SCLK, DIN, DOUT, GPIO4_OUT, GPIO4_OE, GPIO1_DATA_READY, WRITE_STROBE;
  logic [1:0] MODE;
  logic [7:0] SAMPLE_PERIOD_SETTING, WRITE_DATA;
  logic [5:0] WRITE_ADDR;
  logic [15:0] rx;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #20 REF_CLK = ~REF_CLK;
  sspi_host_model host (.clk(REF_CLK), .cs_n(CS_N), .sclk(SCLK), .din(DIN), .dout(DOUT));
  sspi_slave dut (
    .REF_CLK(REF_CLK),
    .RESET(RESET),
    .CS_N(CS_N),
    .SCLK(SCLK),
    .DIN(DIN),
    .DOUT(DOUT),
    .GPIO4_IN(GPIO4_IN),
    .GPIO4_OUT(GPIO4_OUT),
    .GPIO4_OE(GPIO4_OE),
    .GPIO1_DATA_READY(GPIO1_DATA_READY),
    .SAMPLE_LOAD(SAMPLE_LOAD),
    .MODE(MODE),
    .SAMPLE_PERIOD_SETTING(SAMPLE_PERIOD_SETTING),
    .WRITE_STROBE(WRITE_STROBE),
    .WRITE_ADDR(WRITE_ADDR),
    .WRITE_DATA(WRITE_DATA)
  );
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("errors=%0d compares=%0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      test_done();
    end
  end
  task automatic t_wr_rd();
    chk({2'b00, MODE, SAMPLE_PERIOD_SETTING, GPIO4_OE, GPIO4_OUT, GPIO1_DATA_READY, WRITE_STROBE}, 16'h0010);
    host.xfer(16'hA11F, 16, rx);
    chk({WRITE_ADDR, 2'b00, WRITE_DATA}, {6'h21, 2'b00, 8'h1F});
    host.xfer(16'h2000, 16, rx);
    host.xfer(16'h0000, 16, rx);
    chk(rx, 16'h1F00);
    host.xfer(16'hA1FF, 9, rx);
    host.idle_clocks(16);
    chk({WRITE_ADDR, 2'b00, WRITE_DATA}, {6'h21, 2'b00, 8'h1F});
    host.xfer(16'h2000, 16, rx);
    host.xfer(16'h2000, 16, rx);
    chk(rx, 16'h1F00);
  endtask
  task automatic t_mode();
    logic [7:0] v [2] = '{8'h0A, 8'h09};
    foreach (v[i]) begin
      host.xfer({8'hB6, v[i]}, 16, rx);
      repeat (3) @(posedge REF_CLK);
      chk({6'h00, MODE, SAMPLE_PERIOD_SETTING},
          {6'h00, ((v[i] > 8'h09) ? 2'(sspi_pkg::SSPI_LOW_POWER) : 2'(sspi_pkg::SSPI_NORMAL)), v[i]});
    end
    host.xfer(16'h3E00, 16, rx);
    host.xfer(16'h0000, 4, rx);
    chk(16'(MODE), 16'(sspi_pkg::SSPI_BURST));
    host.xfer(16'h0000, 16, rx);
    chk(16'(MODE), 16'(sspi_pkg::SSPI_NORMAL));
  endtask
  task automatic t_sync();
    int n = 0;
    host.xfer(16'hB288, 16, rx);
    repeat (3) @(posedge REF_CLK);
    chk(16'({GPIO4_OE, GPIO4_OUT}), 16'h0003);
    #1 SAMPLE_LOAD = 1'b1;
    @(posedge REF_CLK);
    #1 SAMPLE_LOAD = 1'b0;
    repeat (3) @(posedge REF_CLK);
    chk(16'(GPIO1_DATA_READY), 16'h0001);
    host.xfer(16'hB204, 16, rx);
    repeat (3) @(posedge REF_CLK);
    chk(16'(GPIO4_OE), 16'h0000);
    #1 GPIO4_IN = 1'b1;
    while (GPIO1_DATA_READY !== 1'b1 && n < 15100) begin
      @(posedge REF_CLK);
      #1;
      n++;
      if (n == 125) GPIO4_IN = 1'b0;
    end
    chk(16'(n >= 600 * 25 && n <= 600 * 25 + 10), 16'h0001);
  endtask
  initial begin
    repeat (8) @(posedge REF_CLK);
    #1 RESET = 1'b0;
    repeat (3) @(posedge REF_CLK);
    t_wr_rd();
    t_mode();
    t_sync();
    test_done();
  end
endmodule
